// ### src/interrupt_entry_return_unit.sv
// Purpose: interrupt entry and return for a 32-bit embedded core
// Assumes: core gives one-cycle return pulses and a steady status word
// Notes:   registers are reached over APB, zero wait states
//
// What this block does
// - data/instr storage, external, alignment, program, fpu, apu, syscall, timers, tlb misses are noncritical.
// - machine checks, debug, critical input and watchdog first time-out are critical.
// - noncritical entry saves faulting address, or next address for async and syscall.
// - a multicycle op in progress is aborted and its own address saved.
// - aligned scalar access never issued if interrupted; once issued it is not interrupted.
// - line-fill bit lets noncachable loads fetch a line, unless region is guarded.
// - multiple, string and misaligned crossing accesses may be interrupted and restarted.
// - a terminated load leaves its addressing registers unchanged.
// - restart just rewrites targets already written, no recovery.
// - noncritical entry copies state to saved-state, then loads new state.
// - handler address is vector prefix upper 16 bits joined with vector offset.
// - all sources of one type go to the same vector.
// - noncritical return restores program counter and state from noncritical pair.
// - critical entry saves next address and state into the critical pair.
// - critical return restores program counter and state from critical pair.
// - vector offsets 0x0100 through 0x0800 for the first eight types.
// - vector offsets 0x0C00 through 0x2000 for the remaining types.
// - critical-enable gates critical input and watchdog first time-out.
// - external-enable gates external input and both interval timers.
`include "ier_consts.svh"
module interrupt_entry_return_unit (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire ier_pkg::irq_req_t   irq_req,
  input  wire ier_pkg::core_stat_t core_stat,
  input  wire logic                rfi_exec,
  input  wire logic                rfci_exec,
  output ier_pkg::redirect_t       redirect,
  output logic      [31:0]         machine_state,
  output logic                     abort_multicycle,
  output logic                     bus_cancel,
  output logic                     addr_reg_hold,
  output logic                     fill_whole_line
);
  import ier_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [31:0] machine_state_reg_q;
  logic [31:0] noncrit_return_addr_q;
  logic [31:0] noncrit_saved_state_q;
  logic [31:0] crit_return_addr_q;
  logic [31:0] crit_saved_state_q;
  logic [31:0] vector_prefix_reg_q;
  logic [31:0] core_config_reg_q;
  logic [15:0] cause_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  redirect_t   redirect_q;
  logic        abort_q;
  logic        cancel_q;
  logic        hold_q;
  logic        fill_q;

  logic        take;
  logic        crit;
  logic        use_cur;
  logic [15:0] vec;
  logic        bus_locked;
  logic [31:0] ret_addr;
  logic [31:0] new_state;
  logic        sw_wr;
  logic        setup;
  logic        mapped;
  logic        do_rfi;
  logic        do_rfci;

  // ****************************************
  // entry selection
  // ****************************************
  // an issued aligned scalar access blocks entry until it completes
  assign bus_locked = core_stat.scalar_issued;

  entry_select entry_select_inst (
    .req     (irq_req),
    .machine_state_reg     (machine_state_reg_q),
    .hold    (bus_locked),
    .take    (take),
    .crit    (crit),
    .use_cur (use_cur),
    .vec     (vec)
  );

  // return address choice
  always_comb begin
    ret_addr = core_stat.next_addr;
    if (!crit && use_cur) begin
      ret_addr = core_stat.cur_addr;
    end
    if (core_stat.multicycle) begin
      ret_addr = core_stat.cur_addr;
    end
    if (core_stat.restartable) begin
      ret_addr = core_stat.cur_addr;
    end
  end

  // new machine state: ee off, critical also clears ce
  always_comb begin
    new_state = machine_state_reg_q;
    new_state[31-`EE_POS] = 1'b0;
    if (crit) begin
      new_state[31-`CE_POS] = 1'b0;
    end
  end

  // entry wins over a return in the same cycle
  assign do_rfi  = rfi_exec && !take;
  assign do_rfci = rfci_exec && !take && !rfi_exec;

  // ****************************************
  // apb slave
  // ****************************************
  assign setup  = psel && !penable;
  assign sw_wr  = psel && penable && pwrite && pready_q;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_CAUSE);

  // zero-wait answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
    end
  end

  // read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `RST_WORD;
    end else if (setup) begin
      case (paddr)
        `OFS_MSR:   prdata_q <= machine_state_reg_q;
        `OFS_NRA:   prdata_q <= noncrit_return_addr_q;
        `OFS_NSS:   prdata_q <= noncrit_saved_state_q;
        `OFS_CRA:   prdata_q <= crit_return_addr_q;
        `OFS_CSS:   prdata_q <= crit_saved_state_q;
        `OFS_VPR:   prdata_q <= vector_prefix_reg_q;
        `OFS_CCR:   prdata_q <= core_config_reg_q;
        `OFS_CAUSE: prdata_q <= {16'h0000, cause_q};
        default:    prdata_q <= `RST_WORD;
      endcase
    end
  end

  // ****************************************
  // machine state
  // ****************************************
  // hardware entry and return override a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      machine_state_reg_q <= `RST_WORD;
    end else if (take) begin
      machine_state_reg_q <= new_state;
    end else if (do_rfi) begin
      machine_state_reg_q <= noncrit_saved_state_q;
    end else if (do_rfci) begin
      machine_state_reg_q <= crit_saved_state_q;
    end else if (sw_wr && paddr == `OFS_MSR) begin
      machine_state_reg_q <= pwdata;
    end
  end

  // ****************************************
  // save pairs
  // ****************************************
  // noncritical pair, written on noncritical entry or by a software write, never on critical entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noncrit_return_addr_q <= `RST_WORD;
      noncrit_saved_state_q <= `RST_WORD;
    end else if (take && !crit) begin
      noncrit_return_addr_q <= ret_addr;
      noncrit_saved_state_q <= machine_state_reg_q;
    end else if (sw_wr) begin
      if (paddr == `OFS_NRA) begin
        noncrit_return_addr_q <= pwdata;
      end
      if (paddr == `OFS_NSS) begin
        noncrit_saved_state_q <= pwdata;
      end
    end
  end

  // critical pair, written on critical entry or by a software write, never on noncritical entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crit_return_addr_q <= `RST_WORD;
      crit_saved_state_q <= `RST_WORD;
    end else if (take && crit) begin
      crit_return_addr_q <= ret_addr;
      crit_saved_state_q <= machine_state_reg_q;
    end else if (sw_wr) begin
      if (paddr == `OFS_CRA) begin
        crit_return_addr_q <= pwdata;
      end
      if (paddr == `OFS_CSS) begin
        crit_saved_state_q <= pwdata;
      end
    end
  end

  // ****************************************
  // software-only registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_prefix_reg_q <= `RST_WORD;
      core_config_reg_q   <= `RST_WORD;
    end else if (sw_wr) begin
      if (paddr == `OFS_VPR) begin
        vector_prefix_reg_q <= pwdata;
      end
      if (paddr == `OFS_CCR) begin
        core_config_reg_q <= pwdata;
      end
    end
  end

  // last vector offset taken, read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 16'h0000;
    end else if (take) begin
      cause_q <= vec;
    end
  end

  // ****************************************
  // redirect and core controls
  // ****************************************
  // fetch redirect: handler address or restored program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_q <= '0;
    end else begin
      redirect_q.valid <= take || do_rfi || do_rfci;
      if (take) begin
        redirect_q.addr <= {vector_prefix_reg_q[31:16], vec};
      end else if (do_rfi) begin
        redirect_q.addr <= noncrit_return_addr_q;
      end else if (do_rfci) begin
        redirect_q.addr <= crit_return_addr_q;
      end
    end
  end

  // entry side effects on the executing instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q  <= 1'b0;
      cancel_q <= 1'b0;
      hold_q   <= 1'b0;
    end else begin
      abort_q  <= take && (core_stat.multicycle || core_stat.restartable);
      cancel_q <= take && core_stat.scalar_pend;
      // restart rewrites targets plainly, so only addressing regs are frozen
      hold_q   <= take && core_stat.restartable && core_stat.is_load;
    end
  end

  // whole-line fill for noncachable, unguarded loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 1'b0;
    end else begin
      fill_q <= core_config_reg_q[`LWL_POS] && core_stat.noncache_load
                && !core_stat.guarded;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign redirect         = redirect_q;
  assign machine_state    = machine_state_reg_q;
  assign abort_multicycle = abort_q;
  assign bus_cancel       = cancel_q;
  assign addr_reg_hold    = hold_q;
  assign fill_whole_line  = fill_q;

  // ****************************************
  // assertions
  // ****************************************
  handler_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> redirect.valid && redirect.addr == {$past(vector_prefix_reg_q[31:16]), $past(vec)})
    else $error("handler address not formed from prefix and offset");

  nc_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && !crit) |=> noncrit_saved_state_q == $past(machine_state_reg_q)
                        && machine_state_reg_q[31-`EE_POS] == 1'b0)
    else $error("noncritical entry did not save state");

  crit_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && crit) |=> $stable(noncrit_return_addr_q) && $stable(noncrit_saved_state_q))
    else $error("critical entry touched noncritical pair");

  crit_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && crit && !core_stat.multicycle && !core_stat.restartable)
    |=> crit_return_addr_q == $past(core_stat.next_addr))
    else $error("critical entry saved wrong return address");

  rfi_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rfi_exec && !take) |=> redirect.addr == $past(noncrit_return_addr_q)
                            && machine_state_reg_q == $past(noncrit_saved_state_q))
    else $error("noncritical return restored wrong values");

  rfci_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rfci_exec && !rfi_exec && !take) |=> redirect.valid
                                         && redirect.addr == $past(crit_return_addr_q))
    else $error("critical return restored wrong address");

  bus_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_stat.scalar_issued && !rfi_exec && !rfci_exec) |=> !redirect.valid)
    else $error("issued scalar access was interrupted");

  multi_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && core_stat.multicycle) |=> abort_multicycle
                                      && ($past(crit) ? crit_return_addr_q : noncrit_return_addr_q)
                                         == $past(core_stat.cur_addr))
    else $error("multicycle abort did not save own address");

  ee_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && !machine_state_reg_q[31-`EE_POS]) |=> cause_q != `VEC_EXT && cause_q != `VEC_PIT
                                                   && cause_q != `VEC_FIT)
    else $error("asynchronous interrupt taken while disabled");

  ce_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && !machine_state_reg_q[31-`CE_POS]) |=> cause_q != `VEC_CRIT && cause_q != `VEC_WDOG)
    else $error("critical input taken while disabled");

  line_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_stat.guarded |=> !fill_whole_line)
    else $error("whole line fetched from guarded region");
endmodule

// ### src/ier_consts.svh
// Purpose: constants of the interrupt entry and return unit
// Assumes: 32-bit APB data, word-aligned registers
// Notes:   machine-state bit numbers count from the msb (bit 0 = msb)
`ifndef IER_CONSTS_SVH
`define IER_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MSR    8'h00
`define OFS_NRA    8'h04
`define OFS_NSS    8'h08
`define OFS_CRA    8'h0C
`define OFS_CSS    8'h10
`define OFS_VPR    8'h14
`define OFS_CCR    8'h18
`define OFS_CAUSE  8'h1C

// ****************************************
// field positions and reset values
// ****************************************
`define CE_POS     14
`define EE_POS     16
`define ME_POS     19
`define DE_POS     22
`define LWL_POS    0
`define RST_WORD   32'h0000_0000

// ****************************************
// vector offsets
// ****************************************
`define VEC_CRIT   16'h0100
`define VEC_MCHK   16'h0200
`define VEC_DSTOR  16'h0300
`define VEC_ISTOR  16'h0400
`define VEC_EXT    16'h0500
`define VEC_ALIGN  16'h0600
`define VEC_PROG   16'h0700
`define VEC_FPU    16'h0800
`define VEC_SC     16'h0C00
`define VEC_APU    16'h0F20
`define VEC_PIT    16'h1000
`define VEC_FIT    16'h1010
`define VEC_WDOG   16'h1020
`define VEC_DTLB   16'h1100
`define VEC_ITLB   16'h1200
`define VEC_DEBUG  16'h2000

`endif

// ### src/ier_pkg.sv
// Purpose: types shared by the interrupt entry and return unit
// Assumes: nothing beyond the constants header
// Notes:   one request bit per interrupt source
package ier_pkg;
  // interrupt sources from the core and the timers
  typedef struct packed {
    logic crit_in;
    logic mchk_data;
    logic mchk_instr;
    logic debug;
    logic wdog;
    logic dstor;
    logic istor;
    logic ext_in;
    logic align;
    logic prog;
    logic fpu;
    logic auxiliary_unit;
    logic syscall;
    logic programmable_interval_timer;
    logic fixed_interval_timer;
    logic dtlb;
    logic itlb;
  } irq_req_t;

  // state of the instruction at the head of execution
  typedef struct packed {
    logic [31:0] cur_addr;
    logic [31:0] next_addr;
    logic        multicycle;
    logic        scalar_pend;
    logic        scalar_issued;
    logic        restartable;
    logic        is_load;
    logic        noncache_load;
    logic        guarded;
  } core_stat_t;

  // fetch redirect toward the core
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } redirect_t;
endpackage

// ### src/entry_select.sv
// Purpose: pick one enabled interrupt, its class and vector offset
// Assumes: purely combinational, fixed order
// Notes:   order among sources is a plain fixed chain
`include "ier_consts.svh"
module entry_select
  import ier_pkg::*;
(
  input  wire ier_pkg::irq_req_t req,
  input  wire logic [31:0]       machine_state_reg,
  input  wire logic              hold,
  output logic                   take,
  output logic                   crit,
  output logic                   use_cur,
  output logic [15:0]            vec
);
  logic ce;
  logic ee;
  logic me;
  logic de;

  // enable bits, msb-first numbering
  assign ce = machine_state_reg[31-`CE_POS];
  assign ee = machine_state_reg[31-`EE_POS];
  assign me = machine_state_reg[31-`ME_POS];
  assign de = machine_state_reg[31-`DE_POS];

  // critical sources first, then noncritical; all of one type share a vector
  always_comb begin
    take    = 1'b1;
    crit    = 1'b1;
    use_cur = 1'b0;
    vec     = 16'h0000;
    if (me && (req.mchk_data || req.mchk_instr)) begin
      vec = `VEC_MCHK;
    end else if (de && req.debug) begin
      vec = `VEC_DEBUG;
    end else if (ce && req.crit_in) begin
      vec = `VEC_CRIT;
    end else if (ce && req.wdog) begin
      vec = `VEC_WDOG;
    end else begin
      crit    = 1'b0;
      use_cur = 1'b1;
      if (req.itlb) begin
        vec = `VEC_ITLB;
      end else if (req.istor) begin
        vec = `VEC_ISTOR;
      end else if (req.prog) begin
        vec = `VEC_PROG;
      end else if (req.auxiliary_unit) begin
        vec = `VEC_APU;
      end else if (req.fpu) begin
        vec = `VEC_FPU;
      end else if (req.dtlb) begin
        vec = `VEC_DTLB;
      end else if (req.dstor) begin
        vec = `VEC_DSTOR;
      end else if (req.align) begin
        vec = `VEC_ALIGN;
      end else if (req.syscall) begin
        vec     = `VEC_SC;
        use_cur = 1'b0;
      end else if (ee && req.ext_in) begin
        vec     = `VEC_EXT;
        use_cur = 1'b0;
      end else if (ee && req.fixed_interval_timer) begin
        vec     = `VEC_FIT;
        use_cur = 1'b0;
      end else if (ee && req.programmable_interval_timer) begin
        vec     = `VEC_PIT;
        use_cur = 1'b0;
      end else begin
        take    = 1'b0;
        use_cur = 1'b0;
      end
    end
    if (hold) begin
      take = 1'b0;
    end
  end
endmodule

// ### tb/irq_source_model.sv
// Purpose: model of the interrupt sources and the local bus status
// Assumes: requests are one-cycle pulses, dropped once sampled
// Notes:   every output changes right after a rising edge
module irq_source_model
  import ier_pkg::*;
(
  input  wire logic           pclk,
  output ier_pkg::irq_req_t   irq_req,
  output ier_pkg::core_stat_t core_stat,
  output logic                rfi_exec,
  output logic                rfci_exec
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet sources at time zero
  initial begin
    irq_req   = '0;
    core_stat = '0;
    rfi_exec  = 1'b0;
    rfci_exec = 1'b0;
  end

  // one source raised for one cycle, then dropped
  task automatic raise(input int b);
    @(posedge pclk);
    irq_req <= irq_req_t'(17'h1 << b);
    @(posedge pclk);
    irq_req <= '0;
  endtask

  // one return pulse of the chosen class
  task automatic ret(input logic crit);
    @(posedge pclk);
    rfi_exec  <= !crit;
    rfci_exec <= crit;
    @(posedge pclk);
    rfi_exec  <= 1'b0;
    rfci_exec <= 1'b0;
  endtask

  // new status of the instruction at the head
  task automatic set_stat(input core_stat_t s);
    @(posedge pclk);
    core_stat <= s;
  endtask
endmodule

// ### tb/test_interrupt_entry_return_unit.sv
// Purpose: self-checking bench of the interrupt entry and return unit
// Assumes: zero-wait APB slave, sources from irq_source_model
// Notes:   vector prefix written with junk in its low half
`include "ier_consts.svh"
module test_interrupt_entry_return_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import ier_pkg::*;

  // ****************************************
  // signals and expectations
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, machine_state, rd, raddr, rstate;
  logic        rfi_exec, rfci_exec, abort_multicycle, bus_cancel, addr_reg_hold, fill_whole_line;
  logic        err, got, abrt, canc, hold;
  irq_req_t    irq_req;
  core_stat_t  core_stat;
  redirect_t   redirect;
  int          fail_count = 0, checks_done = 0, cycles = 0;
  localparam logic [31:0] CE  = 32'h1 << (31 - `CE_POS);
  localparam logic [31:0] EE  = 32'h1 << (31 - `EE_POS);
  localparam logic [31:0] ME  = 32'h1 << (31 - `ME_POS);
  localparam logic [31:0] DE  = 32'h1 << (31 - `DE_POS);
  localparam logic [31:0] ALL = CE | EE | ME | DE;
  localparam logic [31:0] CUR = 32'h1000_0100;
  localparam logic [31:0] NXT = 32'h1000_0104;
  localparam logic [16:0] CRIT = 17'h1_F000;
  localparam logic [16:0] USE_NXT = 17'h1_F21C;
  localparam logic [15:0] VEC [17] = '{`VEC_ITLB, `VEC_DTLB, `VEC_FIT, `VEC_PIT, `VEC_SC, `VEC_APU,
    `VEC_FPU, `VEC_PROG, `VEC_ALIGN, `VEC_EXT, `VEC_ISTOR, `VEC_DSTOR, `VEC_WDOG, `VEC_DEBUG,
    `VEC_MCHK, `VEC_MCHK, `VEC_CRIT};

  interrupt_entry_return_unit interrupt_entry_return_unit_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req, .core_stat, .rfi_exec,
    .rfci_exec, .redirect, .machine_state, .abort_multicycle, .bus_cancel, .addr_reg_hold,
    .fill_whole_line);
  irq_source_model irq_source_model_inst (.pclk, .irq_req, .core_stat, .rfi_exec, .rfci_exec);

  // clock of 20 ns
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // cuts a hang short
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask

  // watch three cycles for one redirect
  task automatic wait_redir();
    got = 1'b0;
    repeat (3) begin
      @(posedge pclk);
      if (redirect.valid === 1'b1 && got === 1'b0) begin
        got    = 1'b1;
        raddr  = redirect.addr;
        rstate = machine_state;
        abrt   = abort_multicycle;
        canc   = bus_cancel;
        hold   = addr_reg_hold;
      end
    end
  endtask

  function automatic core_stat_t st(input logic [6:0] f);
    return core_stat_t'({CUR, NXT, f});
  endfunction

  task automatic take(input int b, input logic [31:0] machine_state_reg, input core_stat_t s);
    apb(1'b1, `OFS_MSR, machine_state_reg);
    irq_source_model_inst.set_stat(s);
    irq_source_model_inst.raise(b);
    wait_redir();
  endtask

  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rdchk("reset value", 8'(a * 4), `RST_WORD);
    end
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic t_vectors();
    logic [31:0] oth, eret;
    logic        c;
    for (int b = 0; b < 17; b++) begin
      c    = CRIT[b];
      eret = USE_NXT[b] ? NXT : CUR;
      apb(1'b0, c ? `OFS_NSS : `OFS_CSS, 32'h0);
      oth = rd;
      take(b, ALL, st(7'h00));
      check("taken", {31'h0, got}, 32'h1);
      check("vector", raddr, {16'hABCD, VEC[b]});
      check("new state", rstate, ALL & ~EE & ~(c ? CE : 32'h0));
      rdchk("saved state", c ? `OFS_CSS : `OFS_NSS, ALL);
      rdchk("return addr", c ? `OFS_CRA : `OFS_NRA, eret);
      rdchk("other pair", c ? `OFS_NSS : `OFS_CSS, oth);
      rdchk("cause", `OFS_CAUSE, {16'h0, VEC[b]});
      irq_source_model_inst.ret(c);
      wait_redir();
      check("return pc", raddr, eret);
      check("restored state", rstate, ALL);
    end
  endtask

  task automatic t_gating();
    int          bits [8] = '{9, 3, 2, 16, 12, 15, 14, 13};
    logic [31:0] off;
    for (int i = 0; i < 8; i++) begin
      off = i < 3 ? EE : (i < 5 ? CE : (i < 7 ? ME : DE));
      take(bits[i], ALL & ~off, st(7'h00));
      check("gated", {31'h0, got}, 32'h0);
    end
  endtask

  task automatic t_restart();
    take(9, ALL, st(7'h40));
    check("abort pulse", {31'h0, abrt}, 32'h1);
    rdchk("multicycle addr", `OFS_NRA, CUR);
    take(9, ALL, st(7'h0C));
    check("addr hold", {31'h0, hold}, 32'h1);
    rdchk("restart addr", `OFS_NRA, CUR);
    take(7, ALL, st(7'h10));
    check("issued kept", {31'h0, got}, 32'h0);
    take(7, ALL, st(7'h20));
    check("bus cancel", {31'h0, canc}, 32'h1);
  endtask

  task automatic t_linefill();
    logic [6:0] f [3] = '{7'h02, 7'h03, 7'h02};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_CCR, i < 2 ? 32'h1 : 32'h0);
      irq_source_model_inst.set_stat(st(f[i]));
      repeat (2) @(posedge pclk);
      check("line fill", {31'h0, fill_whole_line}, i == 0 ? 32'h1 : 32'h0);
    end
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("state at reset", machine_state, 32'h0);
    t_reset();
    apb(1'b1, `OFS_VPR, 32'hABCD_1234);
    t_vectors();
    t_gating();
    t_restart();
    t_linefill();
    finish_test();
  end
endmodule
